// >>> hw/pq_link_if.sv
`timescale 1ns/1ps
// Byte-level view of the serial bus: the master owns headers and its data, the node its answers.
interface pq_link_if;
    logic m_vld;
    logic m_sof;
    logic [7:0] m_data;
    logic s_vld;
    logic [7:0] s_data;
    modport master(output m_vld, output m_sof, output m_data, input s_vld, input s_data);
    modport device(input m_vld, input m_sof, input m_data, output s_vld, output s_data);
endinterface

// >>> hw/pq_master.sv
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
// Bus master side: software starts a position query over Wishbone and collects the result.
module pq_master (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    pq_link_if.master link
);
    typedef struct packed {
        pq_pkg::pq_mst_st_t st;
        logic [1:0] mode;
        logic [1:0] lsb_zero;
        logic [5:0] dir_id;
        logic [5:0] prep_id;
        logic [6:0] addr;
        logic [71:0] txbuf;
        logic [3:0] cnt;
        logic [3:0] len;
        logic [3:0] rlen;
        logic [7:0] sum;
        logic [31:0] rbuf;
        logic [15:0] timer;
        logic [31:0] result;
        logic [2:0] irq_st;
        logic [2:0] irq_en;
        logic ack;
        logic [31:0] dat;
        logic m_vld;
        logic m_sof;
        logic [7:0] m_data;
    } pq_mst_state_t;

    pq_mst_state_t q;
    pq_mst_state_t d;
    logic wr;
    logic [2:0] ev;
    logic [15:0] pos_mask;

    assign wr = q.ack && wb_we_i && (wb_sel_i != 4'h0);
    // Low position bits the step mode leaves meaningless are forced to zero.
    assign pos_mask = 16'hffff << q.lsb_zero; // R2

    // ==================================================
    // Register bus and frame engine
    // ==================================================
    always_comb begin
        d = q;
        ev = 3'h0;
        d.m_vld = 1'b0;
        d.m_sof = 1'b0;
        d.ack = wb_cyc_i && wb_stb_i && !q.ack;
        d.dat = 32'h0000_0000;
        case (wb_adr_i)
            pq_pkg::PQ_REG_CTRL: d.dat = {26'h0, q.lsb_zero, 1'b0, q.mode, 1'b0};
            pq_pkg::PQ_REG_IDS: d.dat = {9'h0, q.addr, 2'h0, q.prep_id, 2'h0, q.dir_id};
            pq_pkg::PQ_REG_STATE: d.dat = {31'h0, q.st != pq_pkg::PQ_M_IDLE};
            pq_pkg::PQ_REG_IRQ_STATUS: d.dat = {29'h0, q.irq_st};
            pq_pkg::PQ_REG_IRQ_EN: d.dat = {29'h0, q.irq_en};
            pq_pkg::PQ_REG_RESULT: d.dat = q.result;
            default: d.dat = 32'h0000_0000;
        endcase
        case (q.st)
            pq_pkg::PQ_M_SEND: begin
                d.m_vld = 1'b1;
                d.m_sof = (q.cnt == 4'h0);
                if (q.cnt == q.len + 4'h1) begin
                    d.m_data = ~q.sum; // R17
                end else begin
                    d.m_data = q.txbuf[71:64];
                    if (q.cnt != 4'h0) begin
                        d.sum = pq_pkg::pq_csum_add(q.sum, q.txbuf[71:64]);
                    end
                end
                d.txbuf = {q.txbuf[63:0], 8'h00};
                d.cnt = q.cnt + 4'h1;
                if (q.len == pq_pkg::PQ_ZERO_LEN) begin
                    // A read frame is only a header; the node supplies the rest.
                    d.st = pq_pkg::PQ_M_RECV;
                    d.cnt = 4'h0;
                    d.sum = 8'h00;
                    d.timer = pq_pkg::PQ_RESP_TIMEOUT_CYC;
                end else if (q.cnt == q.len + 4'h1) begin
                    // Prepare frame done: follow with the indirect read frame.
                    d.txbuf = {pq_pkg::PQ_PID_IND_RESP, 64'h0}; // R9
                    d.len = pq_pkg::PQ_ZERO_LEN;
                    d.cnt = 4'h0;
                    d.sum = 8'h00;
                end
            end
            pq_pkg::PQ_M_RECV: begin
                d.timer = q.timer - 16'h0001;
                if (link.s_vld) begin
                    if (q.cnt == q.rlen) begin
                        d.st = pq_pkg::PQ_M_IDLE;
                        if (~q.sum == link.s_data) begin // R17
                            d.result = {q.rbuf[31:24], q.rbuf[7:0], q.rbuf[23:8] & pos_mask}; // R2 R6
                            ev[pq_pkg::PQ_IRQ_DONE] = 1'b1;
                        end else begin
                            ev[pq_pkg::PQ_IRQ_CSUM] = 1'b1;
                        end
                    end else begin
                        d.sum = pq_pkg::pq_csum_add(q.sum, link.s_data);
                        d.cnt = q.cnt + 4'h1;
                        if (q.cnt < pq_pkg::PQ_DIRECT_LEN) begin
                            d.rbuf = {q.rbuf[23:0], link.s_data};
                        end
                    end
                end else if (q.timer == 16'h0000) begin
                    d.st = pq_pkg::PQ_M_IDLE;
                    ev[pq_pkg::PQ_IRQ_TIMEOUT] = 1'b1;
                end
            end
            pq_pkg::PQ_M_IDLE: begin
                d.st = pq_pkg::PQ_M_IDLE;
            end
            default: begin
                d.st = pq_pkg::PQ_M_IDLE;
            end
        endcase
        if (wr) begin
            case (wb_adr_i)
                pq_pkg::PQ_REG_CTRL: begin
                    d.mode = wb_dat_i[2:1];
                    d.lsb_zero = wb_dat_i[5:4];
                    if (wb_dat_i[0] && q.st == pq_pkg::PQ_M_IDLE) begin
                        d.st = pq_pkg::PQ_M_SEND;
                        d.cnt = 4'h0;
                        d.sum = 8'h00;
                        if (wb_dat_i[2:1] == pq_pkg::PQ_MODE_SHORT) begin
                            d.txbuf = {pq_pkg::pq_pid(q.prep_id), 1'b1, pq_pkg::PQ_CMD_READ_POS, // R10
                                       1'b1, q.addr, 48'h0};
                            d.len = pq_pkg::PQ_SHORT_LEN;
                            d.rlen = pq_pkg::PQ_LONG_LEN;
                        end else if (wb_dat_i[2:1] == pq_pkg::PQ_MODE_LONG) begin
                            d.txbuf = {pq_pkg::PQ_PID_LONG_PREP, pq_pkg::PQ_APP_CMD, // R11
                                       1'b1, pq_pkg::PQ_CMD_READ_POS, 1'b1, q.addr, {5{pq_pkg::PQ_FILL}}};
                            d.len = pq_pkg::PQ_LONG_LEN;
                            d.rlen = pq_pkg::PQ_LONG_LEN;
                        end else begin
                            d.txbuf = {pq_pkg::pq_pid(q.dir_id), 64'h0}; // R5 R8
                            d.len = pq_pkg::PQ_ZERO_LEN;
                            d.rlen = pq_pkg::PQ_DIRECT_LEN;
                        end
                    end
                end
                pq_pkg::PQ_REG_IDS: begin
                    d.dir_id = wb_dat_i[5:0];
                    d.prep_id = wb_dat_i[13:8];
                    d.addr = wb_dat_i[22:16];
                end
                pq_pkg::PQ_REG_IRQ_EN: d.irq_en = wb_dat_i[2:0];
                pq_pkg::PQ_REG_IRQ_CLR: d.irq_st = q.irq_st & ~wb_dat_i[2:0];
                default: d.irq_en = q.irq_en;
            endcase
        end
        // A new event wins over a clear written in the same cycle.
        d.irq_st = d.irq_st | ev;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= '{st: pq_pkg::PQ_M_IDLE, default: '0};
        end else begin
            q <= d;
        end
    end

    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.dat;
    assign irq_o = |(q.irq_st & q.irq_en);
    assign link.m_vld = q.m_vld;
    assign link.m_sof = q.m_sof;
    assign link.m_data = q.m_data;
endmodule // pq_master

// >>> hw/pq_node.sv
`timescale 1ns/1ps
// What this block does
// [R1] Position sent signed sixteen bits, high first.
// [R2] Master zeroes meaningless low position bits.
// [R3] Query never clears any status flag.
// [R4] Status byte equals the short status.
// [R5] Direct read frame: four bytes plus checksum.
// [R6] Byte1 switch and address, position, status.
// [R7] Direct identifier bits 5:4 equal 1,0.
// [R8] Master gives each motor one direct identifier.
// [R9] Indirect: prepare first, then read frame.
// [R10] Short prepare: cmd zero, address, checksum.
// [R11] Long prepare: id 3C, 80, fillers.
// [R12] Indirect answer id 7D, eight bytes.
// [R13] Status flag order fixed, temperature low.
// [R14] Both prepare variants give same answer.
// [R15] Position query is command code zero.
// [R16] Answer indirect read only if addressed.
// [R17] Check identifier parity and checksum.
module pq_node (
    input wire logic clk_i,
    input wire logic rst_n_i,
    pq_link_if.device link,
    input wire logic [6:0] node_addr_i,
    input wire logic [5:0] direct_id_i,
    input wire logic [5:0] prep_id_i,
    input wire logic external_switch_state_i,
    input wire logic [15:0] actual_position_i,
    input wire logic supply_reset_flag_i,
    input wire logic step_loss_flag_i,
    input wire logic electrical_defect_flag_i,
    input wire logic undervoltage_flag_i,
    input wire logic thermal_shutdown_flag_i,
    input wire logic thermal_warning_flag_i,
    input wire logic [1:0] temperature_info_i,
    output logic prepared_o
);
    typedef struct packed {
        pq_pkg::pq_dev_st_t st;
        logic [3:0] cnt;
        logic [3:0] len;
        logic long_frm;
        logic [7:0] sum;
        logic [63:0] shreg;
        logic pend;
        logic s_vld;
        logic [7:0] s_data;
    } pq_node_state_t;

    pq_node_state_t q;
    pq_node_state_t d;
    logic [5:0] hdr_id;
    logic hdr_ok;
    logic [31:0] answer;
    logic prep_ok;

    // Length-code field of the identifier, declared ahead of the sequencer that reads it.
    localparam int PQ_HI = pq_pkg::PQ_ID_BIT_LEN_HI;
    localparam int PQ_LO = pq_pkg::PQ_ID_BIT_LEN_LO;

    // ==================================================
    // Answer image
    // ==================================================
    // The answer is sampled once at the header so a moving position cannot tear between its two bytes.
    assign answer = {external_switch_state_i, node_addr_i, // R6
                     actual_position_i[15:8], actual_position_i[7:0], // R1
                     pq_pkg::pq_short_status(supply_reset_flag_i, step_loss_flag_i, // R4 R13
                                             electrical_defect_flag_i, undervoltage_flag_i,
                                             thermal_shutdown_flag_i, thermal_warning_flag_i,
                                             temperature_info_i)};
    // Flags are only read here; nothing drives a clear back into the flag logic.
    // R3

    // Header is accepted only with correct parity bits.
    assign hdr_id = link.m_data[5:0];
    assign hdr_ok = link.m_vld && link.m_sof && (link.m_data == pq_pkg::pq_pid(hdr_id)); // R17

    // A prepare frame is good if its checksum holds and it asks this node for its position.
    always_comb begin
        prep_ok = (~q.sum == link.m_data); // R17
        if (q.long_frm) begin
            prep_ok = prep_ok && (q.shreg[63:56] == pq_pkg::PQ_APP_CMD) // R11
                && (q.shreg[55:48] == {1'b1, pq_pkg::PQ_CMD_READ_POS}) // R15
                && (q.shreg[47:40] == {1'b1, node_addr_i}) // R16
                && (q.shreg[39:0] == {5{pq_pkg::PQ_FILL}}); // R11
        end else begin
            prep_ok = prep_ok && (q.shreg[15:8] == {1'b1, pq_pkg::PQ_CMD_READ_POS}) // R10 R15
                && (q.shreg[7:0] == {1'b1, node_addr_i}); // R16
        end
    end

    // ==================================================
    // Frame sequencer
    // ==================================================
    // A header with correct parity always resynchronises the sequencer, whatever frame was in progress.
    always_comb begin
        d = q;
        d.s_vld = 1'b0;
        case (q.st)
            pq_pkg::PQ_RX: begin
                if (link.m_vld && !link.m_sof) begin
                    if (q.cnt == q.len) begin
                        // Any prepare frame with a good checksum replaces the pending request; one with a bad checksum is dropped.
                        if (~q.sum == link.m_data) begin
                            d.pend = prep_ok; // R9 R16
                        end
                        d.st = pq_pkg::PQ_IDLE;
                    end else begin
                        d.shreg = {q.shreg[55:0], link.m_data};
                        d.sum = pq_pkg::pq_csum_add(q.sum, link.m_data);
                        d.cnt = q.cnt + 4'h1;
                    end
                end
            end
            pq_pkg::PQ_TX: begin
                d.s_vld = 1'b1;
                if (q.cnt == q.len) begin
                    d.s_data = ~q.sum; // R5 R12
                    d.st = pq_pkg::PQ_IDLE;
                end else begin
                    d.s_data = q.shreg[63:56]; // R1
                    d.sum = pq_pkg::pq_csum_add(q.sum, q.shreg[63:56]);
                    d.shreg = {q.shreg[55:0], 8'h00};
                    d.cnt = q.cnt + 4'h1;
                end
            end
            pq_pkg::PQ_IDLE: begin
                d.st = pq_pkg::PQ_IDLE;
            end
            default: begin
                d.st = pq_pkg::PQ_IDLE;
            end
        endcase
        if (hdr_ok) begin
            d.st = pq_pkg::PQ_IDLE;
            d.cnt = 4'h0;
            d.sum = 8'h00;
            if (hdr_id == direct_id_i
                && hdr_id[PQ_HI:PQ_LO] == pq_pkg::PQ_DIRECT_LEN_CODE) begin // R7 R8
                d.st = pq_pkg::PQ_TX;
                d.len = pq_pkg::PQ_DIRECT_LEN; // R5
                d.shreg = {answer, {4{pq_pkg::PQ_FILL}}};
            end else if (link.m_data == pq_pkg::PQ_PID_IND_RESP) begin
                if (q.pend) begin // R16
                    d.st = pq_pkg::PQ_TX;
                    d.len = pq_pkg::PQ_LONG_LEN; // R12 R14
                    d.shreg = {answer, {4{pq_pkg::PQ_FILL}}};
                    d.pend = 1'b0;
                end
            end else if (link.m_data == pq_pkg::PQ_PID_LONG_PREP) begin
                d.st = pq_pkg::PQ_RX; // R11
                d.len = pq_pkg::PQ_LONG_LEN;
                d.long_frm = 1'b1;
            end else if (hdr_id == prep_id_i && !hdr_id[PQ_HI]) begin
                d.st = pq_pkg::PQ_RX; // R10
                d.len = pq_pkg::PQ_SHORT_LEN;
                d.long_frm = 1'b0;
            end
        end
    end

    // Single state register for the whole node.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= '{st: pq_pkg::PQ_IDLE, default: '0};
        end else begin
            q <= d;
        end
    end

    assign link.s_vld = q.s_vld;
    assign link.s_data = q.s_data;
    assign prepared_o = q.pend;
endmodule // pq_node

// >>> hw/pq_pkg.sv
package pq_pkg;
    // ==================================================
    // Frame identifiers and fixed bytes
    // ==================================================
    localparam logic [7:0] PQ_PID_IND_RESP = 8'h7d;
    localparam logic [7:0] PQ_PID_LONG_PREP = 8'h3c;
    localparam logic [7:0] PQ_APP_CMD = 8'h80;
    localparam logic [6:0] PQ_CMD_READ_POS = 7'h00;
    localparam logic [7:0] PQ_FILL = 8'hff;
    localparam logic [1:0] PQ_DIRECT_LEN_CODE = 2'h2;
    localparam logic [3:0] PQ_DIRECT_LEN = 4'h4;
    localparam logic [3:0] PQ_SHORT_LEN = 4'h2;
    localparam logic [3:0] PQ_LONG_LEN = 4'h8;
    localparam logic [3:0] PQ_ZERO_LEN = 4'h0;
    localparam int PQ_ID_BIT_LEN_HI = 5;
    localparam int PQ_ID_BIT_LEN_LO = 4;
    // ==================================================
    // Controller register map
    // ==================================================
    localparam logic [7:0] PQ_REG_CTRL = 8'h00;
    localparam logic [7:0] PQ_REG_IDS = 8'h04;
    localparam logic [7:0] PQ_REG_STATE = 8'h08;
    localparam logic [7:0] PQ_REG_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] PQ_REG_IRQ_EN = 8'h10;
    localparam logic [7:0] PQ_REG_IRQ_CLR = 8'h14;
    localparam logic [7:0] PQ_REG_RESULT = 8'h18;
    localparam int PQ_IRQ_DONE = 0;
    localparam int PQ_IRQ_CSUM = 1;
    localparam int PQ_IRQ_TIMEOUT = 2;
    // ==================================================
    // Timing
    // ==================================================
    localparam int PQ_CLK_PERIOD_NS = 10;
    localparam int PQ_RESP_TIMEOUT_NS = 10000;
    localparam logic [15:0] PQ_RESP_TIMEOUT_CYC = 16'(PQ_RESP_TIMEOUT_NS / PQ_CLK_PERIOD_NS);
    // ==================================================
    // Types and helpers
    // ==================================================
    typedef enum logic [1:0] {PQ_MODE_DIRECT, PQ_MODE_SHORT, PQ_MODE_LONG} pq_mode_t;
    typedef enum logic [1:0] {PQ_IDLE, PQ_RX, PQ_TX} pq_dev_st_t;
    typedef enum logic [1:0] {PQ_M_IDLE, PQ_M_SEND, PQ_M_RECV} pq_mst_st_t;

    // Identifier with both parity bits in bits 7 and 6.
    function automatic logic [7:0] pq_pid(input logic [5:0] id);
        logic p0;
        logic p1;
        p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
        p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
        return {p1, p0, id};
    endfunction

    // Sum with carry folded back in; the frame checksum is its inverse.
    function automatic logic [7:0] pq_csum_add(input logic [7:0] s, input logic [7:0] b);
        logic [8:0] t;
        t = {1'b0, s} + {1'b0, b};
        return t[7:0] + {7'h00, t[8]};
    endfunction

    // Short status byte, shared by every answer that carries it.
    function automatic logic [7:0] pq_short_status(input logic sup, input logic stl, input logic eld,
                                                   input logic uv, input logic thermal_shutdown_flag, input logic tw,
                                                   input logic [1:0] tinfo);
        return {sup, stl, eld, uv, thermal_shutdown_flag, tw, tinfo};
    endfunction
endpackage

// >>> verif/position_query_frames_test.sv
`timescale 1ns/1ps
module position_query_frames_test;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat_w = 32'h0;
    logic [31:0] wb_dat_r;
    logic wb_ack;
    logic irq;
    logic prep;
    logic [6:0] addr_v = 7'h00;
    logic [5:0] did_v = 6'h20;
    logic [5:0] pid_v = 6'h00;
    logic sw_v = 1'b0;
    logic [15:0] pos_v = 16'h0;
    logic [7:0] st_v = 8'h00;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    int mismatches = 0;
    int checks = 0;

    // ==================================================
    // Both ends joined across the byte link
    // ==================================================
    pq_link_if i_pq_link_if();
    pq_master i_pq_master(.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
        .irq_o(irq), .link(i_pq_link_if));
    pq_node i_pq_node(.clk_i(clk_i), .rst_n_i(rst_n_i), .link(i_pq_link_if), .node_addr_i(addr_v),
        .direct_id_i(did_v), .prep_id_i(pid_v), .external_switch_state_i(sw_v), .actual_position_i(pos_v),
        .supply_reset_flag_i(st_v[7]), .step_loss_flag_i(st_v[6]), .electrical_defect_flag_i(st_v[5]),
        .undervoltage_flag_i(st_v[4]), .thermal_shutdown_flag_i(st_v[3]), .thermal_warning_flag_i(st_v[2]),
        .temperature_info_i(st_v[1:0]), .prepared_o(prep));
    pq_query_properties i_pq_query_properties(.clk_i(clk_i), .rst_n_i(rst_n_i), .m_vld(i_pq_link_if.m_vld),
        .m_sof(i_pq_link_if.m_sof), .m_data(i_pq_link_if.m_data), .s_vld(i_pq_link_if.s_vld),
        .s_data(i_pq_link_if.s_data));

    // Free-running 100 MHz clock.
    always #5 clk_i = ~clk_i;

    // ==================================================
    // Checking helpers
    // ==================================================
    task chk(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, want);
        end
    endtask

    task stop_test();
        $display("mismatches=%0d checks=%0d", mismatches, checks);
        if (mismatches == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Read answers are compared against the oldest note, masked to the fields that are defined.
    always @(posedge clk_i) begin
        if (wb_ack === 1'b1 && wb_we === 1'b0 && exp_q.size() > 0)
            chk(wb_dat_r & msk_q.pop_front(), exp_q.pop_front());
    end

    // One classic Wishbone cycle; for a read, d is the expected value and m its mask.
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat_w <= d;
        if (!we) begin
            exp_q.push_back(d & m);
            msk_q.push_back(m);
        end
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (n >= 50)
            mismatches++;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    // Bounded wait for the interrupt line; a long wait counts as a mismatch.
    task wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 3000)
            mismatches++;
    endtask

    // One query with fresh device levels, then the result word and the sticky status are read back.
    task query(input logic [1:0] mode, input logic [1:0] nb);
        logic [15:0] keep;
        keep = 16'hffff << nb;
        @(posedge clk_i);
        pos_v <= 16'($urandom());
        sw_v <= 1'($urandom());
        st_v <= 8'($urandom());
        wb(1'b1, pq_pkg::PQ_REG_CTRL, {26'h0, nb, 1'b0, mode, 1'b1}, 32'h0);
        wait_irq();
        wb(1'b0, pq_pkg::PQ_REG_RESULT, {sw_v, addr_v, st_v, pos_v & keep}, 32'hffffffff);
        wb(1'b0, pq_pkg::PQ_REG_IRQ_STATUS, 32'h1, 32'h7);
        wb(1'b0, pq_pkg::PQ_REG_STATE, 32'h0, 32'h1);
        wb(1'b1, pq_pkg::PQ_REG_IRQ_CLR, 32'h7, 32'h0);
    endtask

    // ==================================================
    // Main sequence
    // ==================================================
    initial begin
        void'($urandom(32'hd838));
        addr_v = 7'($urandom());
        did_v = {2'b10, 4'($urandom())};
        pid_v = {1'b0, 5'($urandom())};
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        wb(1'b1, pq_pkg::PQ_REG_IDS, {9'h0, addr_v, 2'h0, pid_v, 2'h0, did_v}, 32'h0);
        wb(1'b0, pq_pkg::PQ_REG_IDS, {9'h0, addr_v, 2'h0, pid_v, 2'h0, did_v}, 32'h007f3f3f);
        wb(1'b0, 8'h1c, 32'h0, 32'hffffffff);
        wb(1'b1, pq_pkg::PQ_REG_IRQ_EN, 32'h1, 32'h0);
        // Every mode and every masking width, back to back.
        for (int i = 0; i < 6; i++)
            query(2'(i % 3), 2'(i));
        // The last query left mode 2 and one masked bit in the control register.
        wb(1'b0, pq_pkg::PQ_REG_CTRL, 32'h14, 32'h36);
        // A prepare for another node must leave the read frame unanswered; the timeout is masked at first.
        wb(1'b1, pq_pkg::PQ_REG_IDS, {9'h0, addr_v ^ 7'h01, 2'h0, pid_v, 2'h0, did_v}, 32'h0);
        wb(1'b1, pq_pkg::PQ_REG_CTRL, {26'h0, 2'h0, 1'b0, 2'h1, 1'b1}, 32'h0);
        repeat (1100) @(posedge clk_i);
        chk({31'h0, irq}, 32'h0);
        chk({31'h0, prep}, 32'h0);
        wb(1'b0, pq_pkg::PQ_REG_IRQ_STATUS, 32'h4, 32'h7);
        wb(1'b1, pq_pkg::PQ_REG_IRQ_EN, 32'h4, 32'h0);
        @(negedge clk_i);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, pq_pkg::PQ_REG_IRQ_CLR, 32'h4, 32'h0);
        @(negedge clk_i);
        chk({31'h0, irq}, 32'h0);
        stop_test();
    end

    // Watchdog well beyond the 1100-cycle wait and the short queries the sequence needs.
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        stop_test();
    end
endmodule // position_query_frames_test

// >>> verif/pq_query_properties.sv
`timescale 1ns/1ps
// ==================================================
// Link-level checks between the two ends
// ==================================================
module pq_query_properties (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic m_vld,
    input wire logic m_sof,
    input wire logic [7:0] m_data,
    input wire logic s_vld,
    input wire logic [7:0] s_data
);
    logic [7:0] acc_q;
    logic [7:0] prv_q;
    logic h1_q;
    logic h2_q;

    // Own end-around-carry adder, so that the check does not share the design's helper.
    function automatic logic [7:0] add_c(input logic [7:0] s, input logic [7:0] b);
        logic [8:0] t;
        t = {1'b0, s} + {1'b0, b};
        return t[7:0] + {7'h00, t[8]};
    endfunction

    // Running sum of answer bytes; prv_q holds the sum before the latest byte, which is the checksum at the end.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            acc_q <= 8'h00;
            prv_q <= 8'h00;
            h1_q <= 1'b0;
            h2_q <= 1'b0;
        end else begin
            h1_q <= m_vld && m_sof;
            h2_q <= h1_q;
            if (s_vld) begin
                prv_q <= acc_q;
                acc_q <= add_c(acc_q, s_data);
            end else begin
                acc_q <= 8'h00;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence ind_rd_s;
        m_vld && m_sof && m_data == pq_pkg::PQ_PID_IND_RESP;
    endsequence
    sequence long_prep_s;
        m_vld && m_sof && m_data == pq_pkg::PQ_PID_LONG_PREP;
    endsequence
    sequence short_prep_s;
        m_vld && m_sof && !m_data[5];
    endsequence
    sequence direct_s;
        m_vld && m_sof && m_data[5:4] == 2'b10;
    endsequence

    a_sof_needs_valid: assert property (m_sof |-> m_vld) else $error("Frame start without valid byte.");
    a_header_parity: assert property (m_vld && m_sof |-> m_data[6] == (m_data[0] ^ m_data[1] ^ m_data[2] ^ m_data[4])
        && m_data[7] == !(m_data[1] ^ m_data[3] ^ m_data[4] ^ m_data[5])) else $error("Bad header parity.");
    a_short_prep_bytes: assert property (short_prep_s |=> (m_vld && !m_sof && m_data == 8'h80) ##1 (m_vld && m_data[7])
        ##1 (m_vld && !m_sof) ##1 ind_rd_s) else $error("Short prepare frame malformed.");
    a_long_prep_bytes: assert property (long_prep_s |=> (m_vld && m_data == pq_pkg::PQ_APP_CMD) ##1 (m_vld && m_data == 8'h80)
        ##1 (m_vld && m_data[7]) ##1 (m_vld && m_data == pq_pkg::PQ_FILL)[*5] ##1 (m_vld && !m_sof) ##1 ind_rd_s)
        else $error("Long prepare frame malformed.");
    a_answer_after_hdr: assert property ($rose(s_vld) |-> h2_q) else $error("Answer without header two cycles before.");
    a_direct_length: assert property (direct_s ##2 s_vld |-> s_vld[*4] ##1 s_vld ##1 !s_vld)
        else $error("Direct answer length wrong.");
    a_indirect_length: assert property (ind_rd_s ##2 s_vld |-> s_vld[*8] ##1 s_vld ##1 !s_vld)
        else $error("Indirect answer length wrong.");
    a_indirect_fill: assert property (ind_rd_s ##2 s_vld |-> ##4 (s_data == pq_pkg::PQ_FILL)[*4])
        else $error("Indirect filler bytes wrong.");
    a_frame_checksum: assert property ($fell(s_vld) |-> $past(s_data) == ~prv_q)
        else $error("Answer checksum wrong.");
endmodule // pq_query_properties
